// file: rtl/tmr2_map.svh
// Register map and timing constants for the second timer's count and reload core.
// Assumes a host core that strobes SFR writes and bit writes at this address space.
`ifndef TMR2_MAP_SVH
`define TMR2_MAP_SVH
`define TMR2_CTRL_ADDR 8'hC8
`define TMR2_CTRL_BIT_BASE 8'hC8
`define TMR2_CTRL_BIT_TOP 8'hCF
`define TMR2_CTRL_RESET 8'h00
`define TMR2_IN_STOP 2'h0
`define TMR2_IN_TIMER 2'h1
`define TMR2_IN_COUNTER 2'h2
`define TMR2_IN_GATED 2'h3
`define TMR2_RLD_OVF 2'h2
`define TMR2_RLD_EXT 2'h3
`define TMR2_OVF_REQ_BIT 6
`define TMR2_CYCLE_STATES 4'hC
`define TMR2_SAMPLE_STATE 4'h9
`define TMR2_COUNT_STATE 4'h0
`define TMR2_RELOAD_STATE 4'h2
`endif

// file: rtl/tmr2_pkg.sv
// Types for the second timer's count and reload core.
// Assumes tmr2_map.svh supplies the register and timing constants; the phase encodings are defined here.
package tmr2_pkg;
    typedef struct packed {
        logic prescale_select;
        logic irq3_edge_select;
        logic irq2_edge_select;
        logic reload_mode_hi;
        logic reload_mode_lo;
        logic compare_mode_select;
        logic input_select_hi;
        logic input_select_lo;
    } tmr2_ctrl_t;

    typedef struct packed {
        logic wr_byte;
        logic wr_bit;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_val;
    } tmr2_sfr_wr_t;

    typedef enum logic [1:0] {
        TMR2_PH_IDLE = 2'h0,
        TMR2_PH_SAMPLE = 2'h1,
        TMR2_PH_COUNT = 2'h3,
        TMR2_PH_RELOAD = 2'h2
    } tmr2_phase_t;
endpackage

// file: rtl/tmr2_pin_edge.sv
// Pin synchroniser and once-per-machine-cycle falling/rising edge sampler.
// Assumes sample_in pulses once per machine cycle on the core clock.
`timescale 1ns/10ps
`default_nettype none
module tmr2_pin_edge
    import tmr2_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Pin and sample strobe
    input wire logic pin_in,
    input wire logic sample_in,
    // Synchronised level, and edge results valid for one clock after the sample
    output logic level_out,
    output logic fall_out,
    output logic rise_out
);
    logic sync1_reg;
    logic sync2_reg;
    logic samp_reg;
    logic fall_reg;
    logic rise_reg;

    // Pin is asynchronous, two flops before anything reads it
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            samp_reg <= 1'b1;
            fall_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            fall_reg <= sample_in & samp_reg & ~sync2_reg;
            rise_reg <= sample_in & ~samp_reg & sync2_reg;
            // Only the last sample is kept; the edge compares it with the new one
            if (sample_in)
                samp_reg <= sync2_reg;
        end
    end

    assign level_out = sync2_reg;
    assign fall_out = fall_reg;
    assign rise_out = rise_reg;
endmodule
`default_nettype wire

// file: rtl/tmr2_core.sv
// Second 16-bit timer: count source select, overflow flag, 16-bit reload.
// Assumes the CPU core supplies SFR write strobes and flag clears on this clock.
`timescale 1ns/10ps
`default_nettype none
`include "tmr2_map.svh"
module tmr2_core
    import tmr2_pkg::*;
#(
    parameter int COUNT_W = 16
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // SFR write port from the CPU core
    input wire tmr2_sfr_wr_t sfr_wr_in,
    input wire logic count_low_wr_in,
    input wire logic count_high_wr_in,
    input wire logic [COUNT_W-1:0] reload_value_in,
    input wire logic ext_trigger_enable_in,
    // Flag clears from software or interrupt vectoring
    input wire logic overflow_flag_clr_in,
    input wire logic ext_trigger_flag_clr_in,
    // Pins
    input wire logic count_gate_pin_in,
    input wire logic reload_trigger_pin_in,
    input wire logic ext_irq2_pin_in,
    input wire logic ext_irq3_pin_in,
    // State back to the CPU
    output logic [7:0] timer2_control_out,
    output logic [7:0] count_low_byte_out,
    output logic [7:0] count_high_byte_out,
    output logic overflow_flag_out,
    output logic ext_trigger_flag_out,
    output logic ext_irq2_edge_out,
    output logic ext_irq3_edge_out,
    output logic compare_mode_one_out
);
    tmr2_ctrl_t ctrl_reg;
    tmr2_ctrl_t ctrl_next;
    logic [3:0] state_reg;
    logic [3:0] state_next;
    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic presc_reg;
    logic presc_next;
    logic ovf_flag_reg;
    logic ext_flag_reg;
    logic cnt_pend_reg;
    logic rld_pend_reg;
    logic irq2_edge_reg;
    logic irq3_edge_reg;
    tmr2_phase_t phase;

    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] idx,
                                           input logic b);
        logic [7:0] r;
        r = v;
        r[idx] = b;
        return r;
    endfunction

    // Machine cycle phase decode
    wire last_state = (state_reg == (`TMR2_CYCLE_STATES - 4'h1));
    wire sample_strobe = (state_reg == `TMR2_SAMPLE_STATE);
    wire count_strobe = (state_reg == `TMR2_COUNT_STATE);
    wire reload_strobe = (state_reg == `TMR2_RELOAD_STATE);
    assign state_next = last_state ? 4'h0 : state_reg + 4'h1;
    assign phase = sample_strobe ? TMR2_PH_SAMPLE :
                   count_strobe ? TMR2_PH_COUNT :
                   reload_strobe ? TMR2_PH_RELOAD : TMR2_PH_IDLE;

    // Pin edge detectors
    wire cnt_level;
    wire cnt_fall;
    wire trg_fall;
    wire i2_fall;
    wire i2_rise;
    wire i3_fall;
    wire i3_rise;

    tmr2_pin_edge u_cnt (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .pin_in(count_gate_pin_in),
        .sample_in(sample_strobe), .level_out(cnt_level), .fall_out(cnt_fall),
        .rise_out()
    );
    tmr2_pin_edge u_trg (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .pin_in(reload_trigger_pin_in),
        .sample_in(sample_strobe), .level_out(), .fall_out(trg_fall), .rise_out()
    );
    tmr2_pin_edge u_i2 (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .pin_in(ext_irq2_pin_in),
        .sample_in(sample_strobe), .level_out(), .fall_out(i2_fall), .rise_out(i2_rise)
    );
    tmr2_pin_edge u_i3 (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .pin_in(ext_irq3_pin_in),
        .sample_in(sample_strobe), .level_out(), .fall_out(i3_fall), .rise_out(i3_rise)
    );

    // Control register writes, byte or single bit
    wire ctrl_byte_hit = sfr_wr_in.wr_byte & (sfr_wr_in.addr == `TMR2_CTRL_ADDR);
    wire ctrl_bit_hit = sfr_wr_in.wr_bit & (sfr_wr_in.addr >= `TMR2_CTRL_BIT_BASE) &
                        (sfr_wr_in.addr <= `TMR2_CTRL_BIT_TOP);
    wire [2:0] bit_idx = sfr_wr_in.addr[2:0];
    assign ctrl_next = ctrl_byte_hit ? tmr2_ctrl_t'(sfr_wr_in.wdata) :
                       ctrl_bit_hit ? tmr2_ctrl_t'(set_bit(ctrl_reg, bit_idx,
                                                           sfr_wr_in.bit_val)) :
                       ctrl_reg;

    // Count source
    wire [1:0] in_sel = {ctrl_reg.input_select_hi, ctrl_reg.input_select_lo};
    wire [1:0] rld_sel = {ctrl_reg.reload_mode_hi, ctrl_reg.reload_mode_lo};
    wire timer_fn = (in_sel == `TMR2_IN_TIMER);
    // Gate is the live synchronised level, read in the count state, not the once-per-cycle sample
    wire gated_fn = (in_sel == `TMR2_IN_GATED) & cnt_level;
    wire counter_fn = (in_sel == `TMR2_IN_COUNTER);
    // Prescaler toggles only in timer and gated modes; in counter mode it is simply ignored
    wire tick_src = count_strobe & (timer_fn | gated_fn);
    assign presc_next = tick_src ? ~presc_reg : presc_reg;
    wire tick_int = tick_src & (~ctrl_reg.prescale_select | presc_reg);
    wire tick_ext = count_strobe & counter_fn & cnt_pend_reg;
    wire tick = tick_int | tick_ext;

    wire rollover = tick & (&count_reg);
    wire rld_ovf = rollover & (rld_sel == `TMR2_RLD_OVF);
    wire rld_ext = reload_strobe & rld_pend_reg & (rld_sel == `TMR2_RLD_EXT);
    wire [COUNT_W-1:0] count_inc = count_reg + {{(COUNT_W-1){1'b0}}, 1'b1};

    always_comb
    begin
        count_next = count_reg;
        if (rld_ovf | rld_ext)
            count_next = reload_value_in;
        else if (tick)
            count_next = count_inc;
        if (count_low_wr_in)
            count_next[7:0] = sfr_wr_in.wdata;
        if (count_high_wr_in)
            count_next[15:8] = sfr_wr_in.wdata;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= 4'h0;
            ctrl_reg <= tmr2_ctrl_t'(`TMR2_CTRL_RESET);
            count_reg <= '0;
            presc_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            count_reg <= count_next;
            presc_reg <= presc_next;
        end
    end

    // Edge pending flags carry the sample-phase edge to the next cycle's update phase
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            cnt_pend_reg <= 1'b0;
            rld_pend_reg <= 1'b0;
        end
        else
        begin
            cnt_pend_reg <= cnt_fall | (cnt_pend_reg & (phase != TMR2_PH_COUNT));
            rld_pend_reg <= trg_fall | (rld_pend_reg & (phase != TMR2_PH_RELOAD));
        end
    end

    // Sticky flags: a set in the same clock as a clear wins; the irq edge outputs are one-clock pulses
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            ovf_flag_reg <= 1'b0;
            ext_flag_reg <= 1'b0;
            irq2_edge_reg <= 1'b0;
            irq3_edge_reg <= 1'b0;
        end
        else
        begin
            ovf_flag_reg <= rollover | (ovf_flag_reg & ~overflow_flag_clr_in);
            ext_flag_reg <= (trg_fall & ext_trigger_enable_in) |
                            (ext_flag_reg & ~ext_trigger_flag_clr_in);
            irq2_edge_reg <= ctrl_reg.irq2_edge_select ? i2_rise : i2_fall;
            irq3_edge_reg <= ctrl_reg.irq3_edge_select ? i3_rise : i3_fall;
        end
    end

    assign timer2_control_out = ctrl_reg;
    assign count_low_byte_out = count_reg[7:0];
    assign count_high_byte_out = count_reg[15:8];
    assign overflow_flag_out = ovf_flag_reg;
    assign ext_trigger_flag_out = ext_flag_reg;
    assign ext_irq2_edge_out = irq2_edge_reg;
    assign ext_irq3_edge_out = irq3_edge_reg;
    assign compare_mode_one_out = ctrl_reg.compare_mode_select;
endmodule
`default_nettype wire

// file: test/tmr2_core_properties.sv
// Port checker for the timer core: control writes, stop, overflow, trigger flag.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module tmr2_core_properties
    import tmr2_pkg::*;
#(
    parameter int COUNT_W = 16
)
(
    // Watched inputs
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire tmr2_sfr_wr_t sfr_wr_in,
    input wire logic count_low_wr_in,
    input wire logic count_high_wr_in,
    input wire logic [COUNT_W-1:0] reload_value_in,
    input wire logic ext_trigger_enable_in,
    input wire logic overflow_flag_clr_in,
    // Watched outputs
    input wire logic [7:0] timer2_control_out,
    input wire logic [7:0] count_low_byte_out,
    input wire logic [7:0] count_high_byte_out,
    input wire logic overflow_flag_out,
    input wire logic ext_trigger_flag_out,
    input wire logic compare_mode_one_out
);
    wire logic [15:0] cnt = {count_high_byte_out, count_low_byte_out};
    wire logic cwr = count_low_wr_in | count_high_wr_in;
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    sequence s_wrap;
        cnt == 16'hFFFF && !cwr ##1 cnt == 16'h0000;
    endsequence
    sequence s_enable_low;
        (!ext_trigger_enable_in)[*3] ##0 !ext_trigger_flag_out;
    endsequence
    a_ctrl_byte_wr: assert property (
        sfr_wr_in.wr_byte && !sfr_wr_in.wr_bit && sfr_wr_in.addr == 8'hC8
        |=> timer2_control_out == $past(sfr_wr_in.wdata)) else $error("control byte write lost");
    a_ctrl_bit_wr: assert property (
        sfr_wr_in.wr_bit && !sfr_wr_in.wr_byte && sfr_wr_in.addr[7:3] == 5'h19
        |=> timer2_control_out[$past(sfr_wr_in.addr[2:0])] == $past(sfr_wr_in.bit_val))
        else $error("control bit write lost");
    a_cmp_mode: assert property (compare_mode_one_out == timer2_control_out[2])
        else $error("compare mode output wrong");
    a_stop_hold: assert property (
        timer2_control_out[1:0] == 2'h0 && !timer2_control_out[4] && !cwr |=> $stable(cnt))
        else $error("stopped count moved");
    a_ovf_wrap: assert property (s_wrap |-> overflow_flag_out)
        else $error("wrap without overflow flag");
    a_ovf_reload: assert property (
        $rose(overflow_flag_out) && timer2_control_out[4:3] == 2'h2 |-> cnt == reload_value_in)
        else $error("overflow reload missing");
    a_ovf_sticky: assert property (overflow_flag_out && !overflow_flag_clr_in |=> overflow_flag_out)
        else $error("overflow flag dropped");
    a_trig_gate: assert property (s_enable_low |=> !ext_trigger_flag_out)
        else $error("trigger flag set while disabled");
endmodule
bind tmr2_core tmr2_core_properties #(.COUNT_W(COUNT_W)) tmr2_core_properties_inst (
    .core_clk_in, .rst_in, .sfr_wr_in, .count_low_wr_in, .count_high_wr_in, .reload_value_in,
    .ext_trigger_enable_in, .overflow_flag_clr_in, .timer2_control_out, .count_low_byte_out,
    .count_high_byte_out, .overflow_flag_out, .ext_trigger_flag_out, .compare_mode_one_out);
`default_nettype wire

// file: test/tmr2_pin_model.sv
// Far-side pin model for the count/gate pin and the reload trigger pin.
// Assumes the bench requests levels; each is retimed to whole machine cycles.
`timescale 1ns/10ps
`default_nettype none
module tmr2_pin_model
(
    // Clock, reset and level requests
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic count_req_in,
    input wire logic trig_req_in,
    // Pins
    output logic count_gate_pin_out,
    output logic reload_trigger_pin_out
);
    logic [3:0] tick_reg;
    always_ff @(posedge core_clk_in)
    begin
        tick_reg <= (rst_in || tick_reg == 4'hB) ? 4'h0 : tick_reg + 4'h1;
        if (rst_in)
        begin
            // Port latches hold one, so both pins idle high
            count_gate_pin_out <= 1'b1;
            reload_trigger_pin_out <= 1'b1;
        end
        else if (tick_reg == 4'h0)
        begin
            // A level may change only once a machine cycle, so none is missed
            count_gate_pin_out <= count_req_in;
            reload_trigger_pin_out <= trig_req_in;
        end
    end
endmodule
`default_nettype wire

// file: test/tb_tmr2_core.sv
// Self-checking bench for the timer core with its pin model.
// Assumes a 100 MHz core clock and the checker bound to the core.
`timescale 1ns/10ps
`default_nettype none
module tb_tmr2_core;
    import tmr2_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cl_wr = 1'b0, ch_wr = 1'b0, ovf_clr = 1'b0, ext_clr = 1'b0;
    logic en = 1'b1, cnt_req = 1'b1, trg_req = 1'b1, irq2 = 1'b1, irq3 = 1'b1;
    logic ovf, exf, e2, e3, cm, gpin, tpin;
    tmr2_sfr_wr_t sfr = '0;
    logic [15:0] rld = 16'h0000, c0;
    logic [7:0] ctrl, lo, hi, v, n2 = 8'h00, n3 = 8'h00, a2, a3;
    logic [7:0] tcfg [4] = '{8'h18, 8'h18, 8'h08, 8'h10};
    int err_count = 0, total_checks = 0, seed = 77;
    tmr2_pin_model tmr2_pin_model_inst (.core_clk_in(clk), .rst_in(rst), .count_req_in(cnt_req),
        .trig_req_in(trg_req), .count_gate_pin_out(gpin), .reload_trigger_pin_out(tpin));
    tmr2_core tmr2_core_inst (.core_clk_in(clk), .rst_in(rst), .sfr_wr_in(sfr),
        .count_low_wr_in(cl_wr), .count_high_wr_in(ch_wr), .reload_value_in(rld),
        .ext_trigger_enable_in(en), .overflow_flag_clr_in(ovf_clr),
        .ext_trigger_flag_clr_in(ext_clr), .count_gate_pin_in(gpin), .reload_trigger_pin_in(tpin),
        .ext_irq2_pin_in(irq2), .ext_irq3_pin_in(irq3), .timer2_control_out(ctrl),
        .count_low_byte_out(lo), .count_high_byte_out(hi), .overflow_flag_out(ovf),
        .ext_trigger_flag_out(exf), .ext_irq2_edge_out(e2), .ext_irq3_edge_out(e3),
        .compare_mode_one_out(cm));
    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        n2 <= n2 + {7'h0, e2 === 1'b1};
        n3 <= n3 + {7'h0, e3 === 1'b1};
    end
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input tmr2_sfr_wr_t s, input logic [3:0] p);
        @(posedge clk);
        sfr <= s;
        {cl_wr, ch_wr, ovf_clr, ext_clr} <= p;
        @(posedge clk);
        sfr <= '0;
        {cl_wr, ch_wr, ovf_clr, ext_clr} <= 4'h0;
        cyc(1);
    endtask
    task automatic pins(input logic [4:0] p, input int n);
        @(posedge clk);
        {en, cnt_req, trg_req, irq2, irq3} <= p;
        cyc(n);
    endtask
    task automatic wr_ctrl(input logic [7:0] d);
        put({2'b10, 8'hC8, d, 1'b0}, 4'h0);
    endtask
    // Wrap-aware count after n ticks; reload only when the overflow mode is on
    function automatic logic [15:0] f_adv(input logic [15:0] c, input int n, input logic on);
        repeat (n) c = (c == 16'hFFFF) ? (on ? rld : 16'h0000) : c + 16'h1;
        return c;
    endfunction
    // Any 12n consecutive edges hold exactly n count-update states
    task automatic run(input logic [7:0] d, input logic [15:0] s, input int n, input int t);
        wr_ctrl(8'h00);
        put({10'h0, s[7:0], 1'b0}, 4'h8);
        put({10'h0, s[15:8], 1'b0}, 4'h4);
        wr_ctrl(d);
        c0 = {hi, lo};
        cyc(n);
        chk({hi, lo}, f_adv(c0, t, d[4:3] == 2'h2));
    endtask
    initial
    begin
        #100000;
        err_count++;
        test_done();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk({ovf, exf, ctrl, hi, lo}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            if (v[1:0] == 2'h2)
                v[7] = 1'b0;
            wr_ctrl(v);
            chk({cm, ctrl}, {v[2], v});
            put({2'b10, 8'hC9, ~v, 1'b0}, 4'h0);
            put({2'b01, 5'h19, i[2:0], 8'h00, ~v[i]}, 4'h0);
            chk(ctrl, v ^ (8'h01 << i));
        end
        run(8'h00, 16'h1234, 48, 0);
        run(8'h01, 16'h1234, 48, 4);
        run(8'h81, 16'h1234, 48, 2);
        run(8'h03, 16'h1234, 48, 4);
        run(8'h83, 16'h1234, 48, 2);
        pins(5'b10111, 24);
        run(8'h03, 16'h1234, 48, 0);
        run(8'h02, 16'h1234, 48, 0);
        pins(5'b11111, 36);
        repeat (3)
        begin
            pins(5'b10111, 12);
            pins(5'b11111, 12);
        end
        cyc(24);
        chk({hi, lo}, c0 + 16'h3);
        @(posedge clk);
        rld <= 16'($random(seed)) | 16'h1;
        run(8'h01, 16'hFFFE, 36, 3);
        chk(ovf, 1'b1);
        put(19'h0, 4'h2);
        chk(ovf, 1'b0);
        run(8'h11, 16'hFFFE, 36, 3);
        chk(ovf, 1'b1);
        for (int j = 0; j < 4; j++)
        begin
            put(19'h0, 4'h1);
            run(tcfg[j], 16'h1234, 0, 0);
            pins({j != 1, 4'b1011}, 24);
            pins({j != 1, 4'b1111}, 24);
            chk({exf, hi, lo}, {j != 1, tcfg[j][4:3] == 2'h3 ? rld : 16'h1234});
        end
        for (int s = 0; s < 2; s++)
        begin
            wr_ctrl({1'b0, s[0], s[0], 5'h00});
            a2 = n2;
            a3 = n3;
            pins(5'b11100, 36);
            chk({n2 - a2, n3 - a3}, s[0] ? 16'h0000 : 16'h0101);
            pins(5'b11111, 36);
            chk({n2 - a2, n3 - a3}, 16'h0101);
        end
        test_done();
    end
endmodule
`default_nettype wire
